//--- stf_pkg.sv
// Package of constants and types for the sensor teach and diagnostic state machine
// How it works
// - Teach mode: red on, yellow flashes at 1 Hz.
// - Actuator present 10 s in teach: yellow brief 3 Hz flashes ask power cycle.
// - No power cycle within 5 min: abort teach, five red pulses.
// - After power returns, taught code activates and stores once actuator seen again.
// - Single-teach pairs once only; multi-teach allows unlimited reteaching.
// - Teaching a new code invalidates the previous stored code.
// - After reteach, outputs inhibited ten minutes; green flashes until expiry and detection.
// - Power failure during inhibit restarts full 10 min inhibit.
// - Actuator leaving zone drops both safety outputs at once.
// - Green steady with supply, both inputs active, no actuator.
// - Input missing: green flashes 1 Hz, safety outputs off.
// - Limit area: yellow 1 Hz, diagnostic pulsed, safety outputs on.
// - Error: repeating red groups of 1 to 6 pulses by cause.
// - Steady red with yellow flashing while teaching; steady red on internal fault.
// - Internal error drops outputs; cleared by guard open then close after cause gone.
// - Warning: diagnostic low, safety outputs on, red flashes.
// - Warning clears by itself when cause goes.
// - Warning for 30 min switches safety outputs off, red keeps flashing.
// - Actuated, inputs and feedback good: yellow on, green off, diag and outputs high.
// - Awaiting feedback: outputs low, diag high; static waits closure, edge waits falling edge.
// - Actuated but input missing: green flashes, yellow on, diag high, outputs off.
// - Teach and inhibit hold diagnostic and safety outputs low.
package stf_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_HZ = 30;
  localparam int TICK_DIV = CLK_HZ / TICK_HZ;
  localparam int TEACH_HOLD_S = 10;
  localparam int CYCLE_WAIT_MIN = 5;
  localparam int INHIBIT_MIN = 10;
  localparam int WARN_LIMIT_MIN = 30;
  localparam int SEC_PER_MIN = 60;
  localparam int TEACH_HOLD_TICKS = TEACH_HOLD_S * TICK_HZ;
  localparam int CYCLE_WAIT_TICKS = CYCLE_WAIT_MIN * SEC_PER_MIN * TICK_HZ;
  localparam int INHIBIT_TICKS = INHIBIT_MIN * SEC_PER_MIN * TICK_HZ;
  localparam int WARN_LIMIT_TICKS = WARN_LIMIT_MIN * SEC_PER_MIN * TICK_HZ;
  localparam int SLOW_HALF_TICKS = 15;
  localparam int FAST_PERIOD_TICKS = 10;
  localparam int FAST_HALF_TICKS = 5;
  localparam int BRIEF_ON_TICKS = 2;
  localparam int PULSE_TICKS = 6;
  localparam int GROUP_PAUSE_TICKS = 60;
  localparam logic [2:0] CODE_OUT1 = 3'h1;
  localparam logic [2:0] CODE_OUT2 = 3'h2;
  localparam logic [2:0] CODE_CROSS = 3'h3;
  localparam logic [2:0] CODE_TEMP = 3'h4;
  localparam logic [2:0] CODE_ACT = 3'h5;
  localparam logic [2:0] CODE_DISC = 3'h6;

  typedef enum logic [1:0] {
    STF_VAR_SINGLE,
    STF_VAR_MULTI
  } stf_teach_t;

  typedef struct packed {
    logic safetyInputOne;
    logic safetyInputTwo;
    logic actPresent;
    logic actLimit;
    logic actNewCode;
    logic feedback;
  } stf_sense_t;

  typedef struct packed {
    logic out1Fault;
    logic out2Fault;
    logic crossWire;
    logic overTemp;
    logic discrepancy;
    logic internal;
  } stf_fault_t;

  typedef struct packed {
    logic green;
    logic red;
    logic yellow;
  } stf_led_t;
endpackage

//--- stf_flash_gen.sv
`timescale 1ns/1ps
// Prescaler and flash pattern generator
module stf_flash_gen (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Pattern control
  input wire logic [2:0] groupCount,
  // Outputs
  output logic tick,
  output logic slowFlash,
  output logic fastFlash,
  output logic briefFlash,
  output logic groupFlash
);
  import stf_pkg::*;
  logic [25:0] divReg;
  logic [4:0] slowReg;
  logic [3:0] fastReg;
  logic [6:0] phaseReg;
  logic [2:0] pulseReg;
  logic slowReg2;
  logic inPause;
  logic pulseEnd;
  assign inPause = (pulseReg == 3'h0);
  assign pulseEnd = inPause ? (phaseReg == 7'(GROUP_PAUSE_TICKS - 1)) : (phaseReg == 7'(2 * PULSE_TICKS - 1));
  assign slowFlash = slowReg2;
  assign fastFlash = (fastReg < 4'(FAST_HALF_TICKS));
  assign briefFlash = (fastReg < 4'(BRIEF_ON_TICKS));
  assign groupFlash = !inPause && (phaseReg < 7'(PULSE_TICKS));

  // One shared prescaler keeps all blink phases coherent
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      divReg <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (divReg == 26'(TICK_DIV - 1));
      divReg <= (divReg == 26'(TICK_DIV - 1)) ? '0 : divReg + 26'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      slowReg <= '0;
      slowReg2 <= 1'b0;
      fastReg <= '0;
      phaseReg <= '0;
      pulseReg <= '0;
    end else if (tick) begin
      slowReg <= (slowReg == 5'(SLOW_HALF_TICKS - 1)) ? '0 : slowReg + 5'h1;
      if (slowReg == 5'(SLOW_HALF_TICKS - 1)) slowReg2 <= !slowReg2;
      fastReg <= (fastReg == 4'(FAST_PERIOD_TICKS - 1)) ? '0 : fastReg + 4'h1;
      // Pause between groups lets the pulses be counted
      if (pulseEnd) begin
        phaseReg <= '0;
        pulseReg <= inPause ? groupCount : pulseReg - 3'h1;
      end else begin
        phaseReg <= phaseReg + 7'h1;
      end
    end
  end
endmodule // stf_flash_gen

//--- stf_teach_diag.sv
`timescale 1ns/1ps
// Teach-in, inhibit and diagnostic state machine of the safety sensor
module stf_teach_diag #(
  parameter int TEACH_TICKS = stf_pkg::TEACH_HOLD_TICKS,
  parameter int CYCLE_TICKS = stf_pkg::CYCLE_WAIT_TICKS,
  parameter int INHIBIT_TICKS = stf_pkg::INHIBIT_TICKS,
  parameter int WARN_TICKS = stf_pkg::WARN_LIMIT_TICKS,
  parameter stf_pkg::stf_teach_t TEACH_VARIANT = stf_pkg::STF_VAR_MULTI,
  parameter bit EDGE_FEEDBACK = 1'b0
) (
  // Clock and power-on reset
  input wire logic clk,
  input wire logic rst_b,
  // Sensed inputs, asynchronous
  input wire stf_pkg::stf_sense_t senseIn,
  input wire stf_pkg::stf_fault_t faultIn,
  // Non-volatile store: code state survives power loss
  input wire logic nvTeachPending,
  input wire logic nvInhibitPending,
  input wire logic nvPaired,
  output logic nvTeachPendingNext,
  output logic nvInhibitPendingNext,
  output logic nvPairedNext,
  output logic codeCommit,
  output logic codeInvalidate,
  // Outputs
  output logic safetyOutputOne,
  output logic safetyOutputTwo,
  output logic diagOut,
  output stf_pkg::stf_led_t led
);
  import stf_pkg::*;

  typedef enum logic [2:0] {
    ST_BOOT, ST_RUN, ST_TEACH, ST_CYCLE_REQ, ST_TEACH_ABORT, ST_AWAIT_ACT, ST_INHIBIT, ST_ERROR
  } stf_state_t;

  stf_sense_t senseMeta, senseSync;
  stf_fault_t faultMeta, faultSync;
  stf_state_t state_reg, state_next;
  logic [23:0] timer_reg, timer_next;
  logic [23:0] warnTimer_reg;
  logic [2:0] errCode_reg, errCode_next;
  logic teachPend_reg, inhPend_reg, paired_reg;
  logic feedbackOk_reg, fbPrev_reg, guardOpened_reg;
  logic tick, slowFlash, fastFlash, briefFlash, groupFlash;
  logic inputsOk, present, warnActive, warnExpired, hardFault, fbFall, fbGood;
  logic safeOn, diagNext;
  stf_led_t ledNext;
  logic [2:0] groupCount;

  // Two-stage synchronisers; only the second stage is used
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      senseMeta <= '0;
      senseSync <= '0;
      faultMeta <= '0;
      faultSync <= '0;
    end else begin
      senseMeta <= senseIn;
      senseSync <= senseMeta;
      faultMeta <= faultIn;
      faultSync <= faultMeta;
    end
  end

  function automatic logic [2:0] fault_code(input stf_fault_t f);
    if (f.out1Fault) return CODE_OUT1;
    if (f.out2Fault) return CODE_OUT2;
    if (f.crossWire) return CODE_CROSS;
    if (f.overTemp) return CODE_TEMP;
    if (f.discrepancy) return CODE_DISC;
    return 3'h0;
  endfunction

  assign inputsOk = senseSync.safetyInputOne && senseSync.safetyInputTwo;
  assign present = senseSync.actPresent;
  assign warnActive = faultSync.overTemp || faultSync.crossWire;
  assign warnExpired = (warnTimer_reg >= 24'(WARN_TICKS));
  assign hardFault = faultSync.internal || faultSync.out1Fault || faultSync.out2Fault || faultSync.discrepancy;
  assign fbFall = fbPrev_reg && !senseSync.feedback;
  // Static variant needs closure, edge variant a falling edge
  assign fbGood = EDGE_FEEDBACK ? fbFall : senseSync.feedback;
  assign groupCount = errCode_reg;

  stf_flash_gen u_flash (
    .clk(clk),
    .rst_b(rst_b),
    .groupCount(groupCount),
    .tick(tick),
    .slowFlash(slowFlash),
    .fastFlash(fastFlash),
    .briefFlash(briefFlash),
    .groupFlash(groupFlash)
  );

  always_comb begin
    state_next = state_reg;
    timer_next = tick ? timer_reg + 24'h1 : timer_reg;
    errCode_next = errCode_reg;
    nvTeachPendingNext = teachPend_reg;
    nvInhibitPendingNext = inhPend_reg;
    nvPairedNext = paired_reg;
    codeCommit = 1'b0;
    codeInvalidate = 1'b0;
    unique case (state_reg)
      ST_BOOT: begin
        timer_next = '0;
        // Inhibit restarts from zero after any power loss
        if (nvTeachPending) state_next = ST_AWAIT_ACT;
        else if (nvInhibitPending) state_next = ST_INHIBIT;
        else state_next = ST_RUN;
      end
      ST_RUN: begin
        timer_next = '0;
        if (hardFault || warnExpired) begin
          state_next = ST_ERROR;
          errCode_next = faultSync.internal ? 3'h0 : fault_code(faultSync);
        end else if (present && senseSync.actNewCode &&
                     (TEACH_VARIANT == STF_VAR_MULTI || !paired_reg)) begin
          state_next = ST_TEACH;
        end
      end
      ST_TEACH: begin
        if (!present || !senseSync.actNewCode) state_next = ST_RUN;
        else if (timer_reg >= 24'(TEACH_TICKS)) begin
          state_next = ST_CYCLE_REQ;
          timer_next = '0;
          nvTeachPendingNext = 1'b1;
        end
      end
      ST_CYCLE_REQ: begin
        if (timer_reg >= 24'(CYCLE_TICKS)) begin
          state_next = ST_TEACH_ABORT;
          nvTeachPendingNext = 1'b0;
          errCode_next = CODE_ACT;
        end
      end
      ST_TEACH_ABORT: begin
        // Held until actuator removed so the code is seen
        if (!present) state_next = ST_RUN;
      end
      ST_AWAIT_ACT: begin
        timer_next = '0;
        if (present && senseSync.actNewCode) begin
          state_next = ST_INHIBIT;
          codeCommit = 1'b1;
          codeInvalidate = 1'b1;
          nvTeachPendingNext = 1'b0;
          nvInhibitPendingNext = 1'b1;
          nvPairedNext = 1'b1;
        end
      end
      ST_INHIBIT: begin
        // Ends only after time and fresh detection
        if (timer_reg >= 24'(INHIBIT_TICKS) && present) begin
          state_next = ST_RUN;
          nvInhibitPendingNext = 1'b0;
        end
      end
      ST_ERROR: begin
        // Clear needs cause gone plus open and reclose
        if (!hardFault && !warnExpired && guardOpened_reg && present) state_next = ST_RUN;
      end
      default: state_next = ST_BOOT;
    endcase
  end

  // Output decode per state and sensed condition
  always_comb begin
    safeOn = 1'b0;
    diagNext = 1'b0;
    ledNext = '0;
    unique case (state_reg)
      ST_TEACH: begin
        ledNext.red = 1'b1;
        ledNext.yellow = slowFlash;
      end
      ST_CYCLE_REQ: begin
        ledNext.red = 1'b1;
        ledNext.yellow = briefFlash;
      end
      ST_TEACH_ABORT: ledNext.red = groupFlash;
      ST_AWAIT_ACT, ST_INHIBIT: ledNext.green = slowFlash;
      ST_ERROR: begin
        // Internal error entered with no warning active keeps steady red until cleared, not only while its cause stands
        ledNext.red = (faultSync.internal || errCode_reg == 3'h0) ? 1'b1 : groupFlash;
      end
      ST_RUN: begin
        if (!present) begin
          ledNext.green = inputsOk ? 1'b1 : slowFlash;
        end else if (!inputsOk) begin
          ledNext.green = slowFlash;
          ledNext.yellow = 1'b1;
          diagNext = 1'b1;
        end else if (!feedbackOk_reg) begin
          ledNext.green = 1'b1;
          ledNext.yellow = senseSync.actLimit ? (slowFlash ^ fastFlash) : slowFlash;
          diagNext = senseSync.actLimit ? slowFlash : 1'b1;
        end else begin
          safeOn = 1'b1;
          ledNext.yellow = senseSync.actLimit ? slowFlash : 1'b1;
          diagNext = senseSync.actLimit ? slowFlash : 1'b1;
          if (warnActive) begin
            diagNext = 1'b0;
            ledNext.yellow = 1'b0;
            ledNext.red = groupFlash;
          end
        end
      end
      default: ledNext = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_BOOT;
      timer_reg <= '0;
      errCode_reg <= '0;
      teachPend_reg <= 1'b0;
      inhPend_reg <= 1'b0;
      paired_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      errCode_reg <= (state_reg == ST_RUN && warnActive) ? fault_code(faultSync) : errCode_next;
      teachPend_reg <= (state_reg == ST_BOOT) ? nvTeachPending : nvTeachPendingNext;
      inhPend_reg <= (state_reg == ST_BOOT) ? nvInhibitPending : nvInhibitPendingNext;
      paired_reg <= (state_reg == ST_BOOT) ? nvPaired : nvPairedNext;
    end
  end

  // Feedback latch, guard-open memory and warning timer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      feedbackOk_reg <= 1'b0;
      fbPrev_reg <= 1'b0;
      guardOpened_reg <= 1'b0;
      warnTimer_reg <= '0;
    end else begin
      fbPrev_reg <= senseSync.feedback;
      if (!present || !inputsOk || state_reg != ST_RUN) feedbackOk_reg <= 1'b0;
      else if (fbGood) feedbackOk_reg <= 1'b1;
      guardOpened_reg <= (state_reg == ST_ERROR) && (guardOpened_reg || !present);
      if (!warnActive) warnTimer_reg <= '0;
      else if (tick && !warnExpired) warnTimer_reg <= warnTimer_reg + 24'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      safetyOutputOne <= 1'b0;
      safetyOutputTwo <= 1'b0;
      diagOut <= 1'b0;
      led <= '0;
    end else begin
      safetyOutputOne <= safeOn;
      safetyOutputTwo <= safeOn;
      diagOut <= diagNext;
      led <= ledNext;
    end
  end
endmodule // stf_teach_diag

//--- stf_teach_diag_chk.sv
// Assertion checker for the teach and diagnostic state machine
`timescale 1ns/1ps
module stf_teach_diag_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Sensed inputs and stored flags
  input wire stf_pkg::stf_sense_t senseIn,
  input wire stf_pkg::stf_fault_t faultIn,
  input wire logic nvTeachPending,
  input wire logic nvInhibitPending,
  // Outputs
  input wire logic safetyOutputOne,
  input wire logic safetyOutputTwo,
  input wire logic diagOut,
  input wire stf_pkg::stf_led_t led
);
  import stf_pkg::*;
  wire outOff = !safetyOutputOne && !safetyOutputTwo;
  wire bothIn = senseIn.safetyInputOne && senseIn.safetyInputTwo;
  // Red excluded: a latched error may outlive its cause
  wire calm = bothIn && faultIn == 6'h00 && !nvInhibitPending && !senseIn.actNewCode && !led.red;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_remove_drops_out: assert property ($fell(senseIn.actPresent) |-> ##[1:5] outOff)
    else $error("outputs stayed on after actuator left");
  a_input_missing_off: assert property (!bothIn [*5] |-> outOff)
    else $error("outputs on with a safety input missing");
  a_internal_red_off: assert property (faultIn.internal [*5] |-> outOff && led.red)
    else $error("internal fault not shown or outputs on");
  a_teach_holds_low: assert property ((senseIn.actNewCode && !nvTeachPending) [*6] |->
    outOff && !diagOut && led.red)
    else $error("teach mode outputs or red lamp wrong");
  a_ready_green: assert property ((calm && !senseIn.actPresent) [*6] |->
    led.green && !led.yellow && outOff)
    else $error("ready indication wrong");
  a_run_outputs_on: assert property ((calm && senseIn.actPresent && senseIn.feedback && !senseIn.actLimit) [*6]
    |-> !outOff && safetyOutputOne && diagOut && led.yellow && !led.green)
    else $error("actuated state outputs wrong");
  a_feedback_wait: assert property (!senseIn.feedback [*5] ##0 outOff |=> outOff)
    else $error("outputs on with feedback open");
  a_warn_diag_low: assert property ((faultIn.overTemp || faultIn.crossWire) [*6] ##0 safetyOutputOne
    |-> !diagOut)
    else $error("diagnostic high during warning");
  a_warn_auto_clear: assert property ($fell(faultIn.overTemp) && !faultIn.crossWire && !faultIn.internal
    && safetyOutputOne && senseIn.actPresent && !senseIn.actLimit |-> ##[1:6] diagOut)
    else $error("warning did not clear");
  c_run: cover property (safetyOutputOne && diagOut);
  c_warn: cover property (safetyOutputOne && !diagOut);
  c_teach: cover property (senseIn.actNewCode && led.red);
endmodule // stf_teach_diag_chk

//--- stf_nv_model.sv
// Non-volatile store model that keeps code state across power cycles
`timescale 1ns/1ps
module stf_nv_model (
  // Clock and power
  input wire logic clk,
  input wire logic rst_b,
  // Values to store
  input wire logic teachNext,
  input wire logic inhibitNext,
  input wire logic pairedNext,
  // Stored flags
  output logic teachPending,
  output logic inhibitPending,
  output logic paired
);
  // Starts commissioned: one actuator paired, nothing pending
  initial begin
    teachPending = 1'b0;
    inhibitPending = 1'b0;
    paired = 1'b1;
  end
  // Frozen while power is off, so a restart sees the last state
  always @(posedge clk) begin
    if (rst_b) begin
      teachPending <= teachNext;
      inhibitPending <= inhibitNext;
      paired <= pairedNext;
    end
  end
endmodule // stf_nv_model

//--- tb_stf_teach_diag.sv
// Testbench of the teach and diagnostic state machine
`timescale 1ns/1ps
module tb_stf_teach_diag;
  import stf_pkg::*;
  logic clk;
  logic rst_b;
  stf_sense_t senseIn;
  stf_fault_t faultIn;
  logic nvTeach;
  logic nvInhibit;
  logic nvPaired;
  logic tNext;
  logic iNext;
  logic pNext;
  logic safetyOutputOne;
  logic safetyOutputTwo;
  logic diagOut;
  stf_led_t led;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Short 5-tick timers, but the full prescaler gives no tick inside the run, so no timed phase elapses
  stf_teach_diag #(.TEACH_TICKS(5), .CYCLE_TICKS(5), .INHIBIT_TICKS(5), .WARN_TICKS(5)) uut (
    .clk(clk), .rst_b(rst_b), .senseIn(senseIn), .faultIn(faultIn),
    .nvTeachPending(nvTeach), .nvInhibitPending(nvInhibit), .nvPaired(nvPaired),
    .nvTeachPendingNext(tNext), .nvInhibitPendingNext(iNext), .nvPairedNext(pNext),
    .codeCommit(), .codeInvalidate(), .safetyOutputOne(safetyOutputOne),
    .safetyOutputTwo(safetyOutputTwo), .diagOut(diagOut), .led(led));

  stf_nv_model nv (.clk(clk), .rst_b(rst_b), .teachNext(tNext), .inhibitNext(iNext),
    .pairedNext(pNext), .teachPending(nvTeach), .inhibitPending(nvInhibit), .paired(nvPaired));

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Order {out1, out2, diag, green, red, yellow}; mask hides flashing lamps
  task automatic chk(input string what, input logic [5:0] exp, input logic [5:0] mask);
    logic [5:0] seen;
    seen = {safetyOutputOne, safetyOutputTwo, diagOut, led.green, led.red, led.yellow};
    n_compared++;
    if ((seen & mask) !== (exp & mask)) begin
      num_errors++;
      $display("BAD %s expected %b seen %b", what, exp & mask, seen & mask);
    end
  endtask

  // Sense {in1, in2, present, limit, newCode, feedback}
  task automatic drive(input logic [5:0] s, input logic [5:0] f);
    senseIn = s;
    faultIn = f;
    step(8);
  endtask

  task automatic t_idle;
    drive(6'h31, 6'h00);
    chk("ready", 6'h04, 6'h3F);
    drive(6'h21, 6'h00);
    chk("input off", 6'h00, 6'h3B);
    drive(6'h29, 6'h00);
    chk("input off actuated", 6'h09, 6'h3B);
    $display("test idle done");
  endtask

  task automatic t_run;
    drive(6'h39, 6'h00);
    chk("run", 6'h39, 6'h3F);
    drive(6'h3D, 6'h00);
    chk("limit", 6'h30, 6'h36);
    drive(6'h39, 6'h00);
    senseIn = 6'h31;
    step(4);
    chk("removed", 6'h00, 6'h30);
    step(4);
    $display("test run done");
  endtask

  task automatic t_feedback;
    drive(6'h38, 6'h00);
    chk("await feedback", 6'h08, 6'h38);
    drive(6'h39, 6'h00);
    chk("feedback closed", 6'h39, 6'h3F);
    $display("test feedback done");
  endtask

  task automatic t_warn;
    logic [5:0] w [2];
    w = '{6'h04, 6'h08};
    foreach (w[i]) begin
      drive(6'h39, w[i]);
      chk("warning", 6'h30, 6'h3C);
      drive(6'h39, 6'h00);
      chk("warning gone", 6'h39, 6'h3F);
    end
    $display("test warning done");
  endtask

  task automatic t_internal;
    drive(6'h39, 6'h01);
    chk("internal", 6'h02, 6'h32);
    drive(6'h39, 6'h00);
    chk("latched", 6'h02, 6'h32);
    drive(6'h31, 6'h00);
    drive(6'h39, 6'h00);
    chk("reclosed", 6'h39, 6'h3F);
    $display("test internal done");
  endtask

  // Last: teach mode does not end inside this run
  task automatic t_teach;
    drive(6'h31, 6'h00);
    drive(6'h3B, 6'h00);
    chk("teach", 6'h02, 6'h3A);
    $display("test teach done");
  endtask

  initial begin
    rst_b = 1'b0;
    senseIn = 6'h31;
    faultIn = 6'h00;
    step(5);
    rst_b = 1'b1;
    t_idle();
    t_run();
    t_feedback();
    t_warn();
    t_internal();
    t_teach();
    print_verdict();
  end
endmodule // tb_stf_teach_diag

bind stf_teach_diag stf_teach_diag_chk chk (.clk(clk), .rst_b(rst_b), .senseIn(senseIn), .faultIn(faultIn),
  .nvTeachPending(nvTeachPending), .nvInhibitPending(nvInhibitPending), .safetyOutputOne(safetyOutputOne),
  .safetyOutputTwo(safetyOutputTwo), .diagOut(diagOut), .led(led));
